// file: design/estc_cmd_dec.v
// decoder of the received speed/torque control command frame
`timescale 1ns/100ps
`include "estc_consts.vh"
module estc_cmd_dec (
	input wire clk_i, // system clock
	input wire rst_n_i, // sync reset, active low
	input wire [63:0] rx_data_i, // frame bytes, byte 1 in [7:0]
	input wire rx_valid_i, // one-cycle frame strobe
	output reg [1:0] mode_o, // active override mode
	output reg [1:0] cond_o, // speed control condition
	output reg [1:0] prio_o, // override priority
	output reg [15:0] speed_req_o, // requested speed, 0.125 rpm
	output reg [7:0] torque_req_o, // requested torque, offset -125
	output reg [15:0] speed_lim_o, // speed limit
	output reg [7:0] torque_lim_o, // torque limit
	output reg lim_reject_o // pulse: invalid limit frame
);

	wire [1:0] f_mode;
	wire [15:0] f_speed;
	wire [7:0] f_torque;
	wire lim_ok;

	// field extraction
	assign f_mode = rx_data_i[`ESTC_MODE_LSB+1:`ESTC_MODE_LSB];
	assign f_speed = {rx_data_i[23:16], rx_data_i[15:8]};
	assign f_torque = rx_data_i[31:24];
	// both limits must be in range; maximum disables the limit
	assign lim_ok = (f_speed <= `ESTC_SPD_LIM_MAX) &&
		(f_torque <= `ESTC_TRQ_LIM_MAX);

	// command state per received frame
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			mode_o <= `ESTC_MODE_OFF;
			cond_o <= 2'b00;
			prio_o <= `ESTC_PRIO_LOWEST;
			speed_req_o <= 16'h0000;
			torque_req_o <= 8'h00;
			speed_lim_o <= `ESTC_SPD_LIM_MAX;
			torque_lim_o <= `ESTC_TRQ_LIM_MAX;
			lim_reject_o <= 1'b0;
		end else begin
			lim_reject_o <= 1'b0;
			if (rx_valid_i) begin
				case (f_mode)
				`ESTC_MODE_OFF: begin
					mode_o <= `ESTC_MODE_OFF;
				end
				`ESTC_MODE_SPEED: begin
					mode_o <= f_mode;
					cond_o <= rx_data_i[`ESTC_COND_LSB+1:`ESTC_COND_LSB];
					prio_o <= rx_data_i[`ESTC_PRIO_LSB+1:`ESTC_PRIO_LSB];
					speed_req_o <= f_speed;
				end
				`ESTC_MODE_TORQUE: begin
					mode_o <= f_mode;
					cond_o <= rx_data_i[`ESTC_COND_LSB+1:`ESTC_COND_LSB];
					prio_o <= rx_data_i[`ESTC_PRIO_LSB+1:`ESTC_PRIO_LSB];
					torque_req_o <= f_torque;
				end
				default: begin
					// invalid limits keep the previous ones
					if (lim_ok) begin
						mode_o <= f_mode;
						prio_o <= rx_data_i[`ESTC_PRIO_LSB+1:`ESTC_PRIO_LSB];
						speed_lim_o <= f_speed;
						torque_lim_o <= f_torque;
					end else begin
						lim_reject_o <= 1'b1;
					end
				end
				endcase
			end
		end
	end

endmodule

// file: design/estc_consts.vh
// constants of the engine configuration framer and speed/torque decoder
// Overview of operation
// - configuration message uses layout number two
// - speed points at 0.125 rpm per bit
// - torque points 1 percent, offset -125
// - points: idle, rated, max torque, high idle
// - droop from max and rated, 0.0122 percent
// - reference torque fixed, 1 Nm per bit
// - override speed 0.125 rpm, time 0.1 s
// - commanded speed limits at 10 rpm
// - commanded torque limits, offset -125 percent
// - update on map, gain/droop, protection change; protection on entry only
// - smoke, road, command limits change nothing
// - payload over eight bytes, multipacket transport
// - send periodically without request
// - command byte 1 bit fields layout
// - command speed bytes 2-3, torque byte 4
// - mode 00 cancels sender's control
// - mode 01 speed control, torque ignored
// - mode 10 torque control, speed ignored
// - mode 11 sets speed and torque limits
// - priority 00 highest to 11 lowest
// - limits valid only up to FAFF/FA
`ifndef ESTC_CONSTS_VH
`define ESTC_CONSTS_VH

// ----------------------------------------------------------------
// message layout
// ----------------------------------------------------------------
`define ESTC_CFG_LAYOUT 8'h02
`define ESTC_CFG_LEN 6'd28
`define ESTC_FRAME_BYTES 4'd8
`define ESTC_TP_DATA 3'd7
`define ESTC_TP_PACKETS 3'd4
`define ESTC_TP_LAST 3'd3

// ----------------------------------------------------------------
// command byte 1 fields
// ----------------------------------------------------------------
`define ESTC_MODE_LSB 0
`define ESTC_COND_LSB 2
`define ESTC_PRIO_LSB 4
`define ESTC_MODE_OFF 2'b00
`define ESTC_MODE_SPEED 2'b01
`define ESTC_MODE_TORQUE 2'b10
`define ESTC_MODE_LIMIT 2'b11
`define ESTC_PRIO_LOWEST 2'b11
`define ESTC_SPD_LIM_MAX 16'hFAFF
`define ESTC_TRQ_LIM_MAX 8'hFA

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define ESTC_SPD_NONE 16'hFFFF
`define ESTC_TRQ_NONE 8'hFF
`define ESTC_CLK_HZ 25000000
`define ESTC_PERIOD_MS 1000
`define ESTC_PERIOD_CYC (`ESTC_CLK_HZ / 1000 * `ESTC_PERIOD_MS)
`define ESTC_DROOP_SCALE 32'd8197

`endif

// file: design/estc_fifo.v
// small synchronous fifo for the outgoing byte stream
`timescale 1ns/100ps
module estc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire clk_i, // system clock
	input wire rst_n_i, // sync reset, active low
	input wire [WIDTH-1:0] in_data_i, // write data
	input wire in_valid_i, // write request
	output wire in_ready_o, // room available
	output reg [WIDTH-1:0] out_data_o, // read data, registered
	output reg out_valid_o, // read data valid
	input wire out_ready_i // consumer takes data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire do_wr;
	wire do_rd;
	wire pop;

	// ----------------------------------------------------------------
	// flags
	// ----------------------------------------------------------------
	// output register refills whenever it empties or is taken
	assign pop = (count != {(AW+1){1'b0}}) &&
		(!out_valid_o || out_ready_i);
	assign in_ready_o = (count != DEPTH[AW:0]);
	assign do_wr = in_valid_i && in_ready_o;
	assign do_rd = pop;

	// storage, no reset needed on the array
	always @(posedge clk_i) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// pointers, count and output stage
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			out_data_o <= {WIDTH{1'b0}};
			out_valid_o <= 1'b0;
		end else begin
			if (do_wr) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= rd_ptr + 1'b1;
				out_data_o <= mem[rd_ptr];
				out_valid_o <= 1'b1;
			end else if (out_ready_i) begin
				out_valid_o <= 1'b0;
			end
			case ({do_wr, do_rd})
			2'b10: count <= count + 1'b1;
			2'b01: count <= count - 1'b1;
			default: count <= count;
			endcase
		end
	end

endmodule

// file: design/estc_top.v
// engine configuration framer with speed/torque command decoder
`timescale 1ns/100ps
`include "estc_consts.vh"
module estc_top #(
	parameter PERIOD_CYC = `ESTC_PERIOD_CYC
) (
	input wire clk_i, // system clock, 25 MHz
	input wire rst_n_i, // sync reset, active low
	// torque curve, one speed and torque per point, speed only at point 6
	input wire [15:0] idle_speed_i, // point 1 speed, 0.125 rpm
	input wire [7:0] idle_torque_i, // point 1 torque
	input wire [15:0] rated_speed_i, // point 2 speed
	input wire [7:0] rated_torque_i, // point 2 torque
	input wire [15:0] maxtrq_speed_i, // point 3 speed
	input wire [7:0] maxtrq_torque_i, // point 3 torque
	input wire [15:0] p4_speed_i, // point 4 speed
	input wire [7:0] p4_torque_i, // point 4 torque
	input wire [15:0] p5_speed_i, // point 5 speed
	input wire [7:0] p5_torque_i, // point 5 torque
	input wire [15:0] high_idle_speed_i, // point 6 speed
	// droop, fixed fields and command ranges
	input wire [15:0] max_speed_i, // max speed for droop
	input wire [15:0] ref_torque_i, // reference torque, 1 Nm
	input wire [15:0] ovr_speed_i, // max override speed
	input wire [7:0] ovr_time_i, // max override time, 0.1 s
	input wire [7:0] spd_lo_i, // commanded speed low, 10 rpm
	input wire [7:0] spd_hi_i, // commanded speed high, 10 rpm
	input wire [7:0] trq_lo_i, // commanded torque low
	input wire [7:0] trq_hi_i, // commanded torque high
	// update events from engine management
	input wire map_change_i, // pulse: torque map changed
	input wire gain_change_i, // pulse: gain or droop changed
	input wire protect_i, // level: power reduction active
	// received speed/torque control frame
	input wire [63:0] rx_data_i, // received command frame
	input wire rx_valid_i, // pulse: command frame valid
	// payload toward the multipacket transport
	output wire [7:0] tx_data_o, // transport payload byte
	output wire tx_valid_o, // payload byte valid
	input wire tx_ready_i, // transport takes byte
	output reg tx_start_o, // pulse: new multipacket message
	output wire [7:0] cfg_layout_o, // layout number sent
	// decoded command state
	output wire [1:0] mode_o, // active override mode
	output wire [1:0] cond_o, // speed control condition
	output wire [1:0] prio_o, // override priority
	output wire [15:0] speed_req_o, // requested speed
	output wire [7:0] torque_req_o, // requested torque
	output wire [15:0] speed_lim_o, // speed limit
	output wire [7:0] torque_lim_o, // torque limit
	output wire lim_reject_o // pulse: limit frame rejected
);

	// ----------------------------------------------------------------
	// states and storage
	// ----------------------------------------------------------------
	// the fourth state code is unused and falls back to idle
	localparam ST_IDLE = 2'd0;
	localparam ST_DROOP = 2'd1;
	localparam ST_SEND = 2'd2;

	reg [15:0] ref_torque;
	reg ref_loaded;
	reg [15:0] droop;
	reg [15:0] droop_calc;
	reg [1:0] state;
	reg [1:0] next_state;
	reg [4:0] byte_idx;
	reg [31:0] period_cnt;
	reg refresh_req;
	reg protect_d;
	reg [1:0] map_sync;
	reg [1:0] gain_sync;
	reg [1:0] prot_sync;
	reg map_d;
	reg gain_d;
	wire [223:0] image;
	wire [7:0] cur_byte;
	wire fifo_ready;
	wire wr_en;
	wire [31:0] diff;
	wire [47:0] droop_prod;
	wire [47:0] droop_quot;
	wire [15:0] droop_sat;
	wire map_evt;
	wire gain_evt;
	wire prot_evt;
	wire update_evt;
	wire last_byte;

	// layout number is fixed by the build, never by a pin
	assign cfg_layout_o = `ESTC_CFG_LAYOUT;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	// event pins come from other logic; second stage is the only reader
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			map_sync <= 2'b00;
			gain_sync <= 2'b00;
			prot_sync <= 2'b00;
			map_d <= 1'b0;
			gain_d <= 1'b0;
			protect_d <= 1'b0;
		end else begin
			map_sync <= {map_sync[0], map_change_i};
			gain_sync <= {gain_sync[0], gain_change_i};
			prot_sync <= {prot_sync[0], protect_i};
			map_d <= map_sync[1];
			gain_d <= gain_sync[1];
			protect_d <= prot_sync[1];
		end
	end

	// rising edges of the synchronised event levels
	assign map_evt = map_sync[1] && !map_d;
	assign gain_evt = gain_sync[1] && !gain_d;
	// protection counts on entry only; staying reduced asks nothing new
	assign prot_evt = prot_sync[1] && !protect_d;
	// only these three causes refresh; smoke, road, command limits do not
	assign update_evt = map_evt || gain_evt || prot_evt;

	// ----------------------------------------------------------------
	// reference torque, caught once after reset
	// ----------------------------------------------------------------
	// a later map change must not move the 100 percent basis
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			ref_torque <= 16'h0000;
			ref_loaded <= 1'b0;
		end else if (!ref_loaded) begin
			ref_torque <= ref_torque_i;
			ref_loaded <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// droop: (max - rated) / rated in 0.0122 percent steps
	// ----------------------------------------------------------------
	// 1/0.0122 percent is about 8197 counts per unit of speed ratio
	// speed below rated gives no droop rather than a wrapped value
	assign diff = (max_speed_i > rated_speed_i) ?
		{16'h0000, max_speed_i - rated_speed_i} : 32'h0000_0000;
	assign droop_prod = {16'h0000, diff} * {16'h0000, `ESTC_DROOP_SCALE};
	assign droop_quot = droop_prod / {32'h0000_0000, rated_speed_i};
	// a result beyond the field saturates instead of wrapping
	assign droop_sat = (droop_quot[47:16] != 32'h0000_0000) ?
		16'hFFFF : droop_quot[15:0];

	// divider output registered so the long path ends in a flop
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			droop_calc <= 16'h0000;
		end else if (rated_speed_i != 16'h0000) begin
			droop_calc <= droop_sat;
		end
	end

	// ----------------------------------------------------------------
	// payload image, two-byte fields low byte first
	// ----------------------------------------------------------------
	// byte 28 at the top, byte 1 in the lowest eight bits
	assign image = {
		trq_hi_i,
		trq_lo_i,
		spd_hi_i,
		spd_lo_i,
		ovr_time_i,
		ovr_speed_i[15:8],
		ovr_speed_i[7:0],
		ref_torque[15:8],
		ref_torque[7:0],
		droop[15:8],
		droop[7:0],
		high_idle_speed_i[15:8],
		high_idle_speed_i[7:0],
		p5_torque_i,
		p5_speed_i[15:8],
		p5_speed_i[7:0],
		p4_torque_i,
		p4_speed_i[15:8],
		p4_speed_i[7:0],
		maxtrq_torque_i,
		maxtrq_speed_i[15:8],
		maxtrq_speed_i[7:0],
		rated_torque_i,
		rated_speed_i[15:8],
		rated_speed_i[7:0],
		idle_torque_i,
		idle_speed_i[15:8],
		idle_speed_i[7:0]
	};

	// ----------------------------------------------------------------
	// period timer and refresh request
	// ----------------------------------------------------------------
	// timer runs free; a send longer than the period would skip a slot
	// set wins over clear so an event during a send is kept
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			period_cnt <= 32'h0000_0000;
			refresh_req <= 1'b1;
		end else begin
			if (period_cnt >= PERIOD_CYC - 1) begin
				period_cnt <= 32'h0000_0000;
			end else begin
				period_cnt <= period_cnt + 32'h0000_0001;
			end
			if (update_evt) begin
				refresh_req <= 1'b1;
			end else if (state == ST_DROOP) begin
				refresh_req <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// sender state machine
	// ----------------------------------------------------------------
	always @* begin
		next_state = state;
		case (state)
		ST_IDLE: begin
			// periodic send, no request needed
			if (period_cnt >= PERIOD_CYC - 1) begin
				next_state = ST_DROOP;
			end
		end
		ST_DROOP: begin
			// one cycle to load droop and announce the message
			next_state = ST_SEND;
		end
		ST_SEND: begin
			if (wr_en && last_byte) begin
				next_state = ST_IDLE;
			end
		end
		default: begin
			next_state = ST_IDLE;
		end
		endcase
	end

	// fifo room is the only thing that stalls the byte walk
	assign wr_en = (state == ST_SEND) && fifo_ready;
	assign cur_byte = image[{byte_idx, 3'b000} +: 8];
	// widened so the 5-bit index meets the 6-bit length
	assign last_byte = ({1'b0, byte_idx} == `ESTC_CFG_LEN - 6'd1);

	// droop is refreshed on update events and at the first send after reset
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= ST_IDLE;
			byte_idx <= 5'd0;
			droop <= 16'h0000;
			tx_start_o <= 1'b0;
		end else begin
			state <= next_state;
			tx_start_o <= 1'b0;
			if (state == ST_DROOP) begin
				byte_idx <= 5'd0;
				tx_start_o <= 1'b1;
				// droop moves only on an event or the first send after reset, never with each send
				if (refresh_req) begin
					droop <= droop_calc;
				end
			end
			if (wr_en) begin
				byte_idx <= byte_idx + 5'd1;
			end
		end
	end

	// ----------------------------------------------------------------
	// byte buffer toward the multipacket transport
	// ----------------------------------------------------------------
	// transport back-pressure stalls the sender through fifo_ready
	estc_fifo #(
		.WIDTH(8),
		.DEPTH(32),
		.AW(5)
	) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_data_i(cur_byte),
		.in_valid_i(wr_en),
		.in_ready_o(fifo_ready),
		.out_data_o(tx_data_o),
		.out_valid_o(tx_valid_o),
		.out_ready_i(tx_ready_i)
	);

	// ----------------------------------------------------------------
	// command decoder
	// ----------------------------------------------------------------
	estc_cmd_dec u_dec (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.rx_data_i(rx_data_i),
		.rx_valid_i(rx_valid_i),
		.mode_o(mode_o),
		.cond_o(cond_o),
		.prio_o(prio_o),
		.speed_req_o(speed_req_o),
		.torque_req_o(torque_req_o),
		.speed_lim_o(speed_lim_o),
		.torque_lim_o(torque_lim_o),
		.lim_reject_o(lim_reject_o)
	);

endmodule

// file: dv/estc_sink.sv
// transport-side sink that takes the configuration byte stream
`timescale 1ns/100ps
module estc_sink (
	input wire clk_i, // clock
	input wire rst_n_i, // reset, active low
	input wire [7:0] frm_data_i, // byte from framer
	input wire frm_valid_i, // byte valid
	input wire frm_start_i, // message start
	input wire stall_i, // hold ready low
	output reg ready_o // byte taken
);
	reg [1:0] ph;
	reg [5:0] n;
	reg [223:0] msg;
	// ------------------------------------------------
	// pacing and capture
	// ------------------------------------------------
	// ready drops every fourth cycle, as a paced transport would
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			ph <= 2'h0;
			n <= 6'h00;
			ready_o <= 1'b0;
		end else begin
			ph <= ph + 2'h1;
			ready_o <= !stall_i && ph != 2'h2;
			if (frm_start_i) begin
				n <= 6'h00;
			end else if (frm_valid_i && ready_o && n < 6'd28) begin
				msg[8*n +: 8] <= frm_data_i;
				n <= n + 6'h01;
			end
		end
	end
endmodule

// file: dv/estc_top_sva.sv
// checker for the configuration framer and command decoder
`timescale 1ns/100ps
module estc_chk #(
	parameter PERIOD_CYC = 100
) (
	input wire clk_i, // clock
	input wire rst_n_i, // reset, active low
	input wire [63:0] rx_data_i, // command frame
	input wire rx_valid_i, // frame strobe
	input wire [7:0] tx_data_o, // payload byte
	input wire tx_valid_o, // byte valid
	input wire tx_ready_i, // byte taken
	input wire tx_start_o, // message start
	input wire [7:0] cfg_layout_o, // layout number
	input wire [1:0] mode_o, // mode
	input wire [1:0] cond_o, // condition
	input wire [1:0] prio_o, // priority
	input wire [15:0] speed_req_o, // speed
	input wire [7:0] torque_req_o, // torque
	input wire [15:0] speed_lim_o, // speed limit
	input wire [7:0] torque_lim_o, // torque limit
	input wire lim_reject_o // reject pulse
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	wire [1:0] md = rx_data_i[1:0];
	wire [15:0] sp = rx_data_i[23:8];
	wire [7:0] tq = rx_data_i[31:24];
	wire lim_ok = (sp <= 16'hFAFF) && (tq <= 8'hFA);
	wire acc = tx_valid_o && tx_ready_i;
	reg [31:0] per;
	reg [5:0] nb;
	reg seen;
	// ------------------------------------------------
	// cycles and bytes since the last message start
	// ------------------------------------------------
	// first start after reset has no reference, hence seen
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			per <= 32'h0000_0000;
			nb <= 6'h00;
			seen <= 1'b0;
		end else if (tx_start_o) begin
			per <= 32'h0000_0000;
			nb <= {5'h00, acc};
			seen <= 1'b1;
		end else begin
			per <= per + 32'h0000_0001;
			nb <= nb + {5'h00, acc};
		end
	end
	// ------------------------------------------------
	// assertions
	// ------------------------------------------------
	layout_const_a: assert property (cfg_layout_o == 8'h02)
		else $error("layout number wrong");
	start_period_a: assert property (tx_start_o && seen |->
		per == PERIOD_CYC - 1) else $error("message period wrong");
	byte_count_a: assert property (tx_start_o && seen |-> nb == 6'd28)
		else $error("message length wrong");
	tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=>
		tx_valid_o && $stable(tx_data_o)) else $error("byte dropped");
	mode_take_a: assert property (rx_valid_i && md != 2'b11 |=>
		mode_o == $past(md)) else $error("mode not taken");
	speed_cmd_a: assert property (rx_valid_i && md == 2'b01 |=>
		speed_req_o == $past(sp) && prio_o == $past(rx_data_i[5:4])
		&& cond_o == $past(rx_data_i[3:2]) && $stable(torque_req_o))
		else $error("speed command wrong");
	torque_cmd_a: assert property (rx_valid_i && md == 2'b10 |=>
		torque_req_o == $past(tq) && $stable(speed_req_o))
		else $error("torque command wrong");
	limit_set_a: assert property (rx_valid_i && md == 2'b11 && lim_ok
		|=> speed_lim_o == $past(sp) && torque_lim_o == $past(tq)
		&& !lim_reject_o) else $error("limits not set");
	limit_refuse_a: assert property (rx_valid_i && md == 2'b11 && !lim_ok
		|=> lim_reject_o && $stable(speed_lim_o) && $stable(torque_lim_o))
		else $error("bad limits taken");
	limit_keep_a: assert property (rx_valid_i && md != 2'b11 |=>
		$stable(speed_lim_o) && $stable(torque_lim_o))
		else $error("limits changed");
endmodule

bind estc_top estc_chk #(.PERIOD_CYC(PERIOD_CYC)) estc_chk_inst (
	.clk_i, .rst_n_i, .rx_data_i, .rx_valid_i, .tx_data_o, .tx_valid_o,
	.tx_ready_i, .tx_start_o, .cfg_layout_o, .mode_o, .cond_o, .prio_o,
	.speed_req_o, .torque_req_o, .speed_lim_o, .torque_lim_o,
	.lim_reject_o
);

// file: dv/test_estc_top.sv
// self-checking bench for the configuration framer and command decoder
`timescale 1ns/100ps
module test_estc_top;
	reg clk_i = 1'b0;
	reg rst_n_i = 1'b0;
	reg [15:0] idle_speed_i = 16'h1770;
	reg [7:0] idle_torque_i = 8'h8A;
	reg [15:0] rated_speed_i = 16'h3E80;
	reg [7:0] rated_torque_i = 8'hE1;
	reg [15:0] maxtrq_speed_i = 16'h2EE0;
	reg [7:0] maxtrq_torque_i = 8'hF0;
	reg [15:0] p4_speed_i = 16'h2710;
	reg [7:0] p4_torque_i = 8'hC8;
	reg [15:0] p5_speed_i = 16'h1F40;
	reg [7:0] p5_torque_i = 8'hB4;
	reg [15:0] high_idle_speed_i = 16'h4268;
	reg [15:0] max_speed_i = 16'h3E80;
	reg [15:0] ref_torque_i = 16'h0320;
	reg [15:0] ovr_speed_i = 16'h4650;
	reg [7:0] ovr_time_i = 8'h32;
	reg [7:0] spd_lo_i = 8'h50;
	reg [7:0] spd_hi_i = 8'hDC;
	reg [7:0] trq_lo_i = 8'h7D;
	reg [7:0] trq_hi_i = 8'hFA;
	reg map_change_i = 1'b0;
	reg gain_change_i = 1'b0;
	reg protect_i = 1'b0;
	reg [63:0] rx_data_i = 64'h0000_0000_0000_0000;
	reg rx_valid_i = 1'b0;
	reg stall = 1'b0;
	reg rej = 1'b0;
	wire [7:0] tx_data_o, cfg_layout_o, torque_req_o, torque_lim_o;
	wire tx_valid_o, tx_ready_i, tx_start_o, lim_reject_o;
	wire [1:0] mode_o, cond_o, prio_o;
	wire [15:0] speed_req_o, speed_lim_o;
	integer bad_count = 0;
	integer cmp_count = 0;
	// expected payload, byte 1 lowest; droop slot is not compared
	wire [223:0] exm = {trq_hi_i, trq_lo_i, spd_hi_i, spd_lo_i, ovr_time_i,
		ovr_speed_i, 16'h0320, 16'h0000, high_idle_speed_i, p5_torque_i,
		p5_speed_i, p4_torque_i, p4_speed_i, maxtrq_torque_i,
		maxtrq_speed_i, rated_torque_i, rated_speed_i, idle_torque_i,
		idle_speed_i};
	wire [15:0] droop = estc_sink_inst.msg[151:136];
	// ------------------------------------------------
	// design, far side, clock
	// ------------------------------------------------
	estc_top #(.PERIOD_CYC(100)) estc_top_inst (
		.clk_i, .rst_n_i, .idle_speed_i, .idle_torque_i, .rated_speed_i,
		.rated_torque_i, .maxtrq_speed_i, .maxtrq_torque_i, .p4_speed_i,
		.p4_torque_i, .p5_speed_i, .p5_torque_i, .high_idle_speed_i,
		.max_speed_i, .ref_torque_i, .ovr_speed_i, .ovr_time_i, .spd_lo_i,
		.spd_hi_i, .trq_lo_i, .trq_hi_i, .map_change_i, .gain_change_i,
		.protect_i, .rx_data_i, .rx_valid_i, .tx_data_o, .tx_valid_o,
		.tx_ready_i, .tx_start_o, .cfg_layout_o, .mode_o, .cond_o, .prio_o,
		.speed_req_o, .torque_req_o, .speed_lim_o, .torque_lim_o,
		.lim_reject_o);
	estc_sink estc_sink_inst (.clk_i, .rst_n_i, .frm_data_i(tx_data_o),
		.frm_valid_i(tx_valid_o), .frm_start_i(tx_start_o),
		.stall_i(stall), .ready_o(tx_ready_i));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	// ------------------------------------------------
	// shared tasks
	// ------------------------------------------------
	task report_and_stop;
		begin
			$display("compares %0d mismatches %0d", cmp_count, bad_count);
			if (bad_count == 0 && cmp_count > 0) begin
				$display("Test passed");
			end else begin
				$display("Test failed");
			end
			$finish;
		end
	endtask
	task chk(input [15:0] got, input [15:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("Error t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// waits for a start, stalls st+1 cycles when st is nonzero, then collects 28 bytes
	task get_msg(input integer st);
		integer i;
		begin
			i = 0;
			while (tx_start_o !== 1'b1 && i < 400) begin
				@(negedge clk_i);
				i = i + 1;
			end
			stall = (st > 0);
			repeat (st + 1) @(negedge clk_i);
			stall = 1'b0;
			while (estc_sink_inst.n !== 6'd28 && i < 600) begin
				@(negedge clk_i);
				i = i + 1;
			end
			if (i >= 400) begin
				bad_count = bad_count + 1;
				report_and_stop;
			end
		end
	endtask
	task chk_msg;
		integer k;
		reg [7:0] g;
		reg [7:0] e;
		begin
			for (k = 0; k < 28; k = k + 1) begin
				g = estc_sink_inst.msg[8*k +: 8];
				e = exm[8*k +: 8];
				if (k != 17 && k != 18) begin
					chk(16'(g), 16'(e));
				end
			end
		end
	endtask
	task send(input [7:0] b1, input [15:0] sp, input [7:0] tq);
		begin
			@(negedge clk_i);
			rx_data_i = {32'hFFFF_FFFF, tq, sp, b1};
			rx_valid_i = 1'b1;
			@(negedge clk_i);
			rx_valid_i = 1'b0;
			rx_data_i = ~rx_data_i;
			rej = lim_reject_o;
		end
	endtask
	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	task t_frame;
		begin
			chk(16'(tx_valid_o), 16'h0000);
			chk(speed_lim_o, 16'hFAFF);
			chk(16'(prio_o), 16'h0003);
			get_msg(0);
			chk_msg;
			chk(droop, 16'h0000);
			chk(16'(cfg_layout_o), 16'h0002);
			get_msg(40);
			chk_msg;
		end
	endtask
	// no event: droop and reference stay; each event refreshes droop
	task t_update;
		begin
			max_speed_i = 16'h4100;
			ref_torque_i = 16'h0400;
			get_msg(0);
			get_msg(0);
			chk(droop, 16'h0000);
			chk_msg;
			gain_change_i = 1'b1;
			repeat (4) @(negedge clk_i);
			gain_change_i = 1'b0;
			get_msg(0);
			get_msg(0);
			// 4 percent droop is 327 whole steps of 0.0122 percent
			chk(droop, 16'h0147);
			max_speed_i = 16'h3E80;
			map_change_i = 1'b1;
			repeat (4) @(negedge clk_i);
			map_change_i = 1'b0;
			get_msg(0);
			get_msg(0);
			chk(droop, 16'h0000);
			max_speed_i = 16'h4100;
			protect_i = 1'b1;
			get_msg(0);
			get_msg(0);
			chk(droop, 16'h0147);
		end
	endtask
	task t_cmd;
		integer p;
		begin
			for (p = 0; p < 4; p = p + 1) begin
				send({2'b11, p[1:0], p[1:0], 2'b01}, 16'h2580 + 16'(p), 8'hAA);
				chk(16'(prio_o), 16'(p));
				chk(16'(cond_o), 16'(p));
				chk(speed_req_o, 16'h2580 + 16'(p));
				chk(16'(torque_req_o), 16'h0000);
			end
			send(8'hC2, 16'h1234, 8'h96);
			chk(16'(torque_req_o), 16'h0096);
			chk(speed_req_o, 16'h2583);
			send(8'hC3, 16'h3000, 8'hA0);
			chk({speed_lim_o[7:0], torque_lim_o}, 16'h00A0);
			chk(16'(rej), 16'h0000);
			send(8'hC3, 16'hFB00, 8'h10);
			chk(16'(rej), 16'h0001);
			send(8'hC3, 16'h2000, 8'hFB);
			chk(16'(rej), 16'h0001);
			chk(speed_lim_o, 16'h3000);
			send(8'hC0, 16'h1111, 8'h11);
			chk(16'(mode_o), 16'h0000);
			// back to back: torque frame then speed frame
			@(negedge clk_i);
			rx_data_i = {32'hFFFF_FFFF, 8'h64, 16'h0FA0, 8'hC2};
			rx_valid_i = 1'b1;
			@(negedge clk_i);
			rx_data_i = {32'hFFFF_FFFF, 8'h00, 16'h1F40, 8'hC1};
			@(negedge clk_i);
			rx_valid_i = 1'b0;
			chk(16'(torque_req_o), 16'h0064);
			chk(speed_req_o, 16'h1F40);
			chk(16'(mode_o), 16'h0001);
		end
	endtask
	initial begin
		repeat (8) @(negedge clk_i);
		rst_n_i = 1'b1;
		@(negedge clk_i);
		t_frame;
		t_update;
		t_cmd;
		report_and_stop;
	end
endmodule
